// ===== src/rcd_pkg.sv
// constants, register map and carrier types for the reset and clock distribution block
package rcd_pkg;

    // ==========================================================
    // clocking
    localparam int CLK_MHZ = 125;
    localparam int USER_CLK_MHZ = 250;
    localparam int MEM_CLK_MHZ = 200;
    localparam int MEM_REF_MHZ = 200;
    localparam int FAST_MEM_MHZ = 800;
    localparam int HOST_REF_MHZ = 100;

    // ==========================================================
    // sizes
    localparam int NCH = 2;
    localparam int NPORTS = 4;
    localparam int CNT_W = 8;
    localparam int RATIO_W = 8;

    // ==========================================================
    // timing
    localparam int RELEASE_NS = 256;
    localparam int RELEASE_CYC = (RELEASE_NS * CLK_MHZ + 999) / 1000;
    localparam int BEAT_WINDOW_NS = 1000;
    localparam int BEAT_WINDOW_CYC = (BEAT_WINDOW_NS * CLK_MHZ) / 1000;

    // ==========================================================
    // register map, byte addresses
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_EMPTY = 5'h08;
    localparam logic [4:0] OFS_SYNTH = 5'h0c;
    localparam logic [4:0] OFS_CHAN = 5'h10;

    // control bits
    localparam int CTRL_IC_RST = 0;
    localparam int CTRL_FORCE_USER = 1;
    // status bits
    localparam int ST_PIN = 0;
    localparam int ST_LINK = 1;
    localparam int ST_CALIB = 2;
    localparam int ST_UCLK = 3;
    localparam int ST_MCLK = 4;
    localparam int ST_DMA_RUN = 5;
    localparam int ST_USER_RUN = 6;
    localparam int ST_IC_RUN = 7;
    // ratio fields and channel fields
    localparam int SYNTH_DIV_LSB = 8;
    localparam int CHAN_C2H_LSB = 8;

    localparam logic [RATIO_W-1:0] MULT_RST = RATIO_W'(FAST_MEM_MHZ / MEM_REF_MHZ);
    localparam logic [RATIO_W-1:0] DIV_RST = 8'h01;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [4:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;

    typedef struct packed {
        logic core_n;
        logic dma_n;
        logic ic_n;
        logic virtual_packet_fifo_n;
        logic raw_n;
    } rst_out_s;

endpackage

// ===== src/reset_clock_distribution.sv
// reset and clock distribution with a classic wishbone register slave
// ==========================================================
// Function
// - card reset pin low holds endpoint, transceivers and memory controller in reset.
// - pin release lets those blocks start their own initialization directly.
// - endpoint link-up and memory calibration-done are raised when initialization completes.
// - user resets combine link-up with calibration-done; held until both report.
// - card reset pin is the primary reset and resets every block.
// - link loss resets dma, packet fifo and raw data only.
// - each dma channel gives active-low software reset per direction.
// - channel software reset resets packet fifo and raw data, nothing else.
// - 250 MHz wrapper clock serves dma, packet fifo and raw data.
// - 200 MHz memory clock serves packet fifo memory side and interconnect.
// - 800 MHz made in memory controller from 200 MHz via multiplier and divider.
// - one empty flag per packet fifo port for memory and preview fifos.
// - memory controller core reset follows the card reset pin.
module reset_clock_distribution
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire rcd_pkg::wb_req_s wb_req,
    output rcd_pkg::wb_rsp_s wb_rsp,
    // pins and status from other blocks, all foreign
    input wire logic card_reset_pin_n,
    input wire logic link_up,
    input wire logic calib_done,
    input wire logic user_clk_beat,
    input wire logic mem_clk_beat,
    input wire logic [rcd_pkg::NCH-1:0] host_to_card_channel_reset_n,
    input wire logic [rcd_pkg::NCH-1:0] card_to_host_channel_reset_n,
    input wire logic [rcd_pkg::NPORTS-1:0] buffer_fifos_empty_flags,
    // derived resets
    output rcd_pkg::rst_out_s resets,
    output logic interconnect_memport_reset_n,
    // clock synthesizer ratios
    output logic [rcd_pkg::RATIO_W-1:0] synth_mult,
    output logic [rcd_pkg::RATIO_W-1:0] synth_div
);
    import rcd_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        // two-stage synchronisers, stage one read by stage two only
        logic pin_s1;
        logic pin_s2;
        logic link_s1;
        logic link_s2;
        logic cal_s1;
        logic cal_s2;
        logic [NCH-1:0] h2c_s1;
        logic [NCH-1:0] h2c_s2;
        logic [NCH-1:0] c2h_s1;
        logic [NCH-1:0] c2h_s2;
        logic [NPORTS-1:0] empty_s1;
        logic [NPORTS-1:0] empty_s2;

        // beat edge detectors, a third stage for the edge
        logic ubeat_s1;
        logic ubeat_s2;
        logic ubeat_s3;
        logic mbeat_s1;
        logic mbeat_s2;
        logic mbeat_s3;

        // clock watchdogs
        logic [CNT_W-1:0] ubeat_cnt;
        logic [CNT_W-1:0] mbeat_cnt;
        logic uclk_alive;
        logic mclk_alive;

        // release stretchers, one per reset group except core
        logic [CNT_W-1:0] dma_cnt;
        logic [CNT_W-1:0] user_cnt;
        logic [CNT_W-1:0] ic_cnt;

        // software controls and synthesizer ratio
        logic ic_sw_rst;
        logic force_user;
        logic [RATIO_W-1:0] mult;
        logic [RATIO_W-1:0] div;

        // registered outputs
        rst_out_s outs;
        logic ic_out_n;
        wb_rsp_s rsp;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    // counter end points, cut to the counter width on purpose
    localparam logic [CNT_W-1:0] REL_MAX = CNT_W'(RELEASE_CYC);
    localparam logic [CNT_W-1:0] BEAT_MAX = CNT_W'(BEAT_WINDOW_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // ==========================================================
    // helpers
    // hold clears the stretch, so assertion is immediate and release is counted
    function automatic logic [CNT_W-1:0] stretch(input logic hold, input logic [CNT_W-1:0] cnt);
        logic [CNT_W-1:0] r;
        r = cnt;
        if (hold)
        begin
            r = CNT_ZERO;
        end
        else if (cnt != REL_MAX)
        begin
            r = cnt + CNT_ONE;
        end
        return r;
    endfunction

    // a beat edge restarts the window; the window running out marks the clock dead
    function automatic logic [CNT_W-1:0] watch(input logic edge_seen, input logic [CNT_W-1:0] cnt);
        logic [CNT_W-1:0] r;
        r = cnt;
        if (edge_seen)
        begin
            r = CNT_ZERO;
        end
        else if (cnt != BEAT_MAX)
        begin
            r = cnt + CNT_ONE;
        end
        return r;
    endfunction

    // release only once the stretch has run out and no cause is left
    function automatic logic released(input logic hold, input logic [CNT_W-1:0] cnt);
        logic r;
        r = 1'b0;
        if (~hold && (cnt == REL_MAX))
        begin
            r = 1'b1;
        end
        return r;
    endfunction

    // ==========================================================
    // next state
    logic wb_hit;
    logic [31:0] rd_word;
    logic user_hold;
    logic dma_hold;
    logic ic_hold;
    logic chan_rst;

    always_comb
    begin
        state_nxt = state_r;

        // ==========================================================
        // synchronisers
        // two-stage synchronisers; stage one feeds only stage two
        state_nxt.pin_s1 = card_reset_pin_n;
        state_nxt.pin_s2 = state_r.pin_s1;
        state_nxt.link_s1 = link_up;
        state_nxt.link_s2 = state_r.link_s1;
        state_nxt.cal_s1 = calib_done;
        state_nxt.cal_s2 = state_r.cal_s1;
        state_nxt.h2c_s1 = host_to_card_channel_reset_n;
        state_nxt.h2c_s2 = state_r.h2c_s1;
        state_nxt.c2h_s1 = card_to_host_channel_reset_n;
        state_nxt.c2h_s2 = state_r.c2h_s1;
        state_nxt.empty_s1 = buffer_fifos_empty_flags;
        state_nxt.empty_s2 = state_r.empty_s1;
        state_nxt.ubeat_s1 = user_clk_beat;
        state_nxt.ubeat_s2 = state_r.ubeat_s1;
        state_nxt.ubeat_s3 = state_r.ubeat_s2;
        state_nxt.mbeat_s1 = mem_clk_beat;
        state_nxt.mbeat_s2 = state_r.mbeat_s1;
        state_nxt.mbeat_s3 = state_r.mbeat_s2;

        // ==========================================================
        // clock watchdogs
        // clock presence of the 250 MHz and 200 MHz domains
        state_nxt.ubeat_cnt = watch(state_r.ubeat_s2 ^ state_r.ubeat_s3, state_r.ubeat_cnt);
        state_nxt.mbeat_cnt = watch(state_r.mbeat_s2 ^ state_r.mbeat_s3, state_r.mbeat_cnt);
        state_nxt.uclk_alive = (state_r.ubeat_cnt != BEAT_MAX);
        state_nxt.mclk_alive = (state_r.mbeat_cnt != BEAT_MAX);
        // a beat that stops mid-run shows as a dead clock one window later

        // ==========================================================
        // reset causes
        // any channel in either direction pulling its reset low
        chan_rst = ~(&state_r.h2c_s2) | ~(&state_r.c2h_s2);

        // core blocks follow the pin alone and start as soon as it rises
        state_nxt.outs.core_n = state_r.pin_s2;

        // dma: pin or link loss, and needs its 250 MHz clock
        dma_hold = ~state_r.pin_s2;
        dma_hold = dma_hold | ~state_r.link_s2;
        dma_hold = dma_hold | ~state_r.uclk_alive;

        // packet fifo and raw data wait for link, calibration and both clocks
        user_hold = ~state_r.pin_s2;
        user_hold = user_hold | ~state_r.link_s2 | ~state_r.cal_s2;
        user_hold = user_hold | chan_rst;
        user_hold = user_hold | state_r.force_user;
        user_hold = user_hold | ~state_r.uclk_alive;
        user_hold = user_hold | ~state_r.mclk_alive;

        // interconnect: pin, software request or dead 200 MHz clock, never link or channel resets
        ic_hold = ~state_r.pin_s2;
        ic_hold = ic_hold | ~state_r.mclk_alive;
        ic_hold = ic_hold | state_r.ic_sw_rst;

        // ==========================================================
        // release stretchers
        // a one-cycle cause still restarts the full stretch, by intent
        state_nxt.dma_cnt = stretch(dma_hold, state_r.dma_cnt);
        state_nxt.user_cnt = stretch(user_hold, state_r.user_cnt);
        state_nxt.ic_cnt = stretch(ic_hold, state_r.ic_cnt);
        state_nxt.outs.dma_n = released(dma_hold, state_r.dma_cnt);
        state_nxt.outs.virtual_packet_fifo_n = released(user_hold, state_r.user_cnt);
        state_nxt.outs.raw_n = released(user_hold, state_r.user_cnt);
        state_nxt.outs.ic_n = released(ic_hold, state_r.ic_cnt);
        // the memory port reset is a second copy, so it needs no fan-out from outs
        state_nxt.ic_out_n = released(ic_hold, state_r.ic_cnt);

        // ==========================================================
        // wishbone slave, one wait state, ack for one cycle
        // ack blocks a hit in the acking cycle, so a held request is taken again every second cycle
        wb_hit = wb_req.cyc & wb_req.stb & ~state_r.rsp.ack;
        state_nxt.rsp.ack = wb_hit;

        // read mux, decoded from the live address
        rd_word = '0;
        unique case (wb_req.adr)
            OFS_CTRL:
            begin
                rd_word[CTRL_IC_RST] = state_r.ic_sw_rst;
                rd_word[CTRL_FORCE_USER] = state_r.force_user;
            end
            OFS_STATUS:
            begin
                rd_word[ST_PIN] = state_r.pin_s2;
                rd_word[ST_LINK] = state_r.link_s2;
                rd_word[ST_CALIB] = state_r.cal_s2;
                rd_word[ST_UCLK] = state_r.uclk_alive;
                rd_word[ST_MCLK] = state_r.mclk_alive;
                rd_word[ST_DMA_RUN] = state_r.outs.dma_n;
                rd_word[ST_USER_RUN] = state_r.outs.virtual_packet_fifo_n;
                rd_word[ST_IC_RUN] = state_r.outs.ic_n;
            end
            OFS_EMPTY:
            begin
                rd_word[NPORTS-1:0] = state_r.empty_s2;
            end
            OFS_SYNTH:
            begin
                rd_word[RATIO_W-1:0] = state_r.mult;
                rd_word[SYNTH_DIV_LSB +: RATIO_W] = state_r.div;
            end
            OFS_CHAN:
            begin
                rd_word[NCH-1:0] = state_r.h2c_s2;
                rd_word[CHAN_C2H_LSB +: NCH] = state_r.c2h_s2;
            end
            default:
            begin
                rd_word = '0;
            end
        endcase
        // read data stands until the next read, so a write leaves it alone
        if (wb_hit & ~wb_req.we)
        begin
            state_nxt.rsp.dat = rd_word;
        end

        // ==========================================================
        // register writes
        // writes land at the acking edge; unmapped writes are dropped
        if (wb_hit & wb_req.we & wb_req.sel[0])
        begin
            unique case (wb_req.adr)
                OFS_CTRL:
                begin
                    // software must see the empty flags first; not enforced here
                    state_nxt.ic_sw_rst = wb_req.dat[CTRL_IC_RST];
                    state_nxt.force_user = wb_req.dat[CTRL_FORCE_USER];
                end
                OFS_SYNTH:
                begin
                    state_nxt.mult = wb_req.dat[RATIO_W-1:0];
                end
                default:
                begin
                    state_nxt.ic_sw_rst = state_r.ic_sw_rst;
                end
            endcase
        end
        if (wb_hit & wb_req.we & wb_req.sel[1] & (wb_req.adr == OFS_SYNTH))
        begin
            state_nxt.div = wb_req.dat[SYNTH_DIV_LSB +: RATIO_W];
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // every reset output comes up asserted
            state_r <= '0;
            // clocks count as dead until their first beat edge is seen
            state_r.ubeat_cnt <= BEAT_MAX;
            state_r.mbeat_cnt <= BEAT_MAX;
            // channel resets idle high, so no false channel reset follows rst
            state_r.h2c_s1 <= '1;
            state_r.h2c_s2 <= '1;
            state_r.c2h_s1 <= '1;
            state_r.c2h_s2 <= '1;
            // ratio starts at 800 MHz from the 200 MHz reference
            state_r.mult <= MULT_RST;
            state_r.div <= DIV_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // outputs, all straight from flip-flops
    // no logic after the registers, so pins change only on clk
    assign wb_rsp = state_r.rsp;
    assign resets = state_r.outs;
    assign interconnect_memport_reset_n = state_r.ic_out_n;
    assign synth_mult = state_r.mult;
    assign synth_div = state_r.div;

endmodule // reset_clock_distribution

// ===== verification/rcd_props.sv
// assertion checker for the reset and clock distribution block
// ==========================================================
// checker
module rcd_props
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // observed ports
    input wire rcd_pkg::wb_req_s wb_req,
    input wire rcd_pkg::wb_rsp_s wb_rsp,
    input wire logic card_reset_pin_n,
    input wire logic link_up,
    input wire logic calib_done,
    input wire rcd_pkg::rst_out_s resets,
    input wire logic interconnect_memport_reset_n,
    input wire logic [rcd_pkg::RATIO_W-1:0] synth_mult,
    input wire logic [rcd_pkg::RATIO_W-1:0] synth_div
);
    import rcd_pkg::*;
    logic [2:0] up_r;
    // age since reset, so the $past of AST_CORE_PIN and AST_LINK_DMA never looks into the reset
    always_ff @(posedge clk)
    begin
        if (rst)
            up_r <= 3'h0;
        else if (up_r != 3'h7)
            up_r <= up_r + 3'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_CORE_PIN: assert property (
        up_r > 3'h4 |-> resets.core_n == $past(card_reset_pin_n, 3))
        else $error("core reset not following pin");
    AST_PIN_ALL: assert property (
        !resets.core_n |-> resets == 5'h00)
        else $error("pin reset not reaching every block");
    AST_LINK_DMA: assert property (
        up_r > 3'h4 && !$past(link_up, 3) |-> !resets.dma_n && !resets.virtual_packet_fifo_n)
        else $error("link loss not resetting dma side");
    AST_LINK_IC: assert property (
        $fell(link_up) && card_reset_pin_n && resets.ic_n |=> resets.ic_n [*4])
        else $error("link loss reset the interconnect");
    AST_USER_CAUSE: assert property (
        resets.virtual_packet_fifo_n |-> $past(link_up, 3) && $past(calib_done, 3))
        else $error("user logic released too early");
    AST_SW_PAIR: assert property (
        resets.virtual_packet_fifo_n == resets.raw_n && (resets.dma_n || !resets.virtual_packet_fifo_n))
        else $error("packet fifo and raw resets disagree");
    AST_IC_PORT: assert property (
        interconnect_memport_reset_n == resets.ic_n)
        else $error("memory port reset differs");
    AST_HOLD_RELEASE: assert property (
        $rose(link_up) |-> ##4 !resets.dma_n [*8])
        else $error("dma reset released without delay");
    AST_ACK_ONE: assert property (
        wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack ##1 !wb_rsp.ack)
        else $error("bus ack timing wrong");
    AST_SYNTH_RST: assert property (
        $past(rst) |-> synth_mult == MULT_RST && synth_div == DIV_RST && resets == 5'h00)
        else $error("reset values wrong");
endmodule // rcd_props

bind reset_clock_distribution rcd_props u_props
(
    .clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .card_reset_pin_n(card_reset_pin_n), .link_up(link_up), .calib_done(calib_done),
    .resets(resets), .interconnect_memport_reset_n(interconnect_memport_reset_n),
    .synth_mult(synth_mult), .synth_div(synth_div)
);

// ===== verification/rcd_far_side.sv
// model of slot, endpoint, memory controller and dma around the block
// ==========================================================
// far side
module rcd_far_side
(
    // clock
    input wire logic clk,
    // commands from the bench
    input wire logic hold_pin,
    input wire logic drop_link,
    input wire logic [3:0] sw_rst,
    // modelled outputs
    output logic card_reset_pin_n,
    output logic link_up,
    output logic calib_done,
    output logic user_clk_beat,
    output logic mem_clk_beat,
    output logic [1:0] h2c_n,
    output logic [1:0] c2h_n
);
    logic [7:0] age_r = 8'h00;
    logic [2:0] beat_r = 3'h0;
    // pin restarts both trainings; calibration is slow on purpose
    always_ff @(posedge clk)
    begin
        beat_r <= beat_r + 3'h1;
        if (hold_pin)
            age_r <= 8'h00;
        else if (age_r != 8'hff)
            age_r <= age_r + 8'h01;
    end
    assign card_reset_pin_n = !hold_pin;
    assign link_up = age_r > 8'h14 && !drop_link;
    assign calib_done = age_r > 8'h80;
    assign user_clk_beat = beat_r[2];
    assign mem_clk_beat = beat_r[1];
    assign h2c_n = ~sw_rst[1:0];
    assign c2h_n = ~sw_rst[3:2];
endmodule // rcd_far_side

// ===== verification/test_reset_clock_distribution.sv
// self-checking bench for the reset and clock distribution block
// ==========================================================
// bench
module test_reset_clock_distribution;
    timeunit 1ns;
    timeprecision 1ps;
    import rcd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wb_req_s wb_req = '0;
    wb_rsp_s wb_rsp;
    rst_out_s resets;
    logic hold_pin = 1'b0;
    logic drop_link = 1'b0;
    logic [3:0] sw_rst = 4'h0;
    logic [3:0] empty_flags = 4'hf;
    logic pin_n, link, calib, ubeat, mbeat, ic_n;
    logic [1:0] h2c_n, c2h_n;
    logic [7:0] mult, div;
    logic [31:0] rd;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    rcd_far_side u_far (.clk(clk), .hold_pin(hold_pin), .drop_link(drop_link),
        .sw_rst(sw_rst), .card_reset_pin_n(pin_n), .link_up(link), .calib_done(calib),
        .user_clk_beat(ubeat), .mem_clk_beat(mbeat), .h2c_n(h2c_n), .c2h_n(c2h_n));
    reset_clock_distribution u_dut (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .card_reset_pin_n(pin_n), .link_up(link), .calib_done(calib), .user_clk_beat(ubeat),
        .mem_clk_beat(mbeat), .host_to_card_channel_reset_n(h2c_n),
        .card_to_host_channel_reset_n(c2h_n), .buffer_fifos_empty_flags(empty_flags),
        .resets(resets), .interconnect_memport_reset_n(ic_n), .synth_mult(mult),
        .synth_div(div));
    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // classic single cycle; ack is looked at only on rising edges
    task automatic wb(input logic we, input logic [4:0] adr, input logic [3:0] sel,
        input logic [31:0] dat);
        int n;
        n = 0;
        wb_req <= '{1'b1, 1'b1, we, adr, sel, dat};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_rsp.ack !== 1'b1);
        chk("ack wait", 32'h2, n);
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk);
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        while (resets !== 5'h1f && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        chk("resets up", 32'h1f, {27'h0, resets});
    endtask
    task automatic s_bringup();
        wt(80);
        chk("dma early", 32'h1, {31'h0, resets.dma_n});
        chk("user early", 32'h0, {31'h0, resets.virtual_packet_fifo_n});
        wait_run();
        wb(1'b0, OFS_STATUS, 4'hf, 32'h0);
        chk("status", 32'hff, rd);
    endtask
    task automatic s_regs();
        wb(1'b0, OFS_SYNTH, 4'hf, 32'h0);
        chk("synth", {16'h0, DIV_RST, MULT_RST}, rd);
        wb(1'b1, OFS_SYNTH, 4'h2, 32'h0000_0a05);
        chk("mult", {24'h0, MULT_RST}, {24'h0, mult});
        chk("div", 32'ha, {24'h0, div});
        wb(1'b0, 5'h14, 4'hf, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, OFS_SYNTH, 4'h3, {16'h0, DIV_RST, MULT_RST});
    endtask
    task automatic s_ic();
        empty_flags <= 4'h5;
        wt(4);
        wb(1'b0, OFS_EMPTY, 4'hf, 32'h0);
        chk("empty", 32'h5, rd);
        empty_flags <= 4'hf;
        wt(4);
        wb(1'b0, OFS_EMPTY, 4'hf, 32'h0);
        chk("empty", 32'hf, rd);
        wb(1'b1, OFS_CTRL, 4'h1, 32'h1);
        wt(3);
        chk("ic held", 32'h1b, {26'h0, ic_n, resets});
        wb(1'b1, OFS_CTRL, 4'h1, 32'h2);
        wt(3);
        chk("forced", 32'h18, {27'h0, resets});
        wb(1'b0, OFS_CTRL, 4'hf, 32'h0);
        chk("ctrl", 32'h2, rd);
        wb(1'b1, OFS_CTRL, 4'h1, 32'h0);
        wait_run();
    endtask
    task automatic s_link_loss();
        drop_link <= 1'b1;
        wt(5);
        chk("link loss", 32'h14, {27'h0, resets});
        drop_link <= 1'b0;
        wait_run();
    endtask
    task automatic s_sw_reset();
        for (int i = 0; i < 4; i++)
        begin
            sw_rst <= 4'(1 << i);
            wt(5);
            chk("sw reset", 32'h1c, {27'h0, resets});
            wb(1'b0, OFS_CHAN, 4'hf, 32'h0);
            chk("chan", {22'h0, ~sw_rst[3:2], 6'h0, ~sw_rst[1:0]}, rd);
            sw_rst <= 4'h0;
            wait_run();
        end
    endtask
    task automatic s_pin();
        hold_pin <= 1'b1;
        wt(4);
        chk("pin held", 32'h0, {27'h0, resets});
        hold_pin <= 1'b0;
        wt(4);
        chk("core up", 32'h1, {31'h0, resets.core_n});
        wait_run();
    endtask
    // limit well beyond the several hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    initial
    begin
        wt(6);
        rst <= 1'b0;
        s_bringup();
        s_regs();
        s_ic();
        s_link_loss();
        s_sw_reset();
        s_pin();
        conclude();
    end
endmodule // test_reset_clock_distribution
